// ==== logic/free_interval_timer.sv ====
// Free-running counter and interval timer with APB registers
`timescale 1ns/1ps
`default_nettype none
module free_interval_timer (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic timer_src_in,
    input wire timer_pkg::apb_req_t apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out
);

    // ****************************************
    // State
    // ****************************************
    logic src_meta, src_sync, src_prev;
    logic [15:0] count, next_count;
    logic [7:0] low_hold, next_low_hold;
    logic [7:0] snap_high, next_snap_high;
    logic [11:0] pit_count, next_pit_count;
    logic [3:0] pit_snap, next_pit_snap;
    logic [11:0] reload, next_reload;
    logic [2:0] status, next_status;
    logic [2:0] mask, next_mask;
    logic [31:0] prdata, next_prdata;

    // ****************************************
    // Decode
    // ****************************************
    logic src_edge, setup, access, rd_setup, wr_acc, mapped;
    logic [7:0] idx;
    logic [2:0] events;

    assign setup = apb_in.psel & ~apb_in.penable;
    assign access = apb_in.psel & apb_in.penable;
    assign rd_setup = setup & ~apb_in.pwrite;
    assign wr_acc = access & apb_in.pwrite & mapped;
    assign idx = apb_in.paddr[9:2];
    // Source edge seen only after two flops
    assign src_edge = src_sync & ~src_prev;

    // Address check, misaligned counts as unmapped
    always_comb begin
        case (idx)
            timer_pkg::FREE_LOW_IDX, timer_pkg::FREE_HIGH_IDX,
            timer_pkg::PIT_LOW_IDX, timer_pkg::PIT_HIGH_IDX,
            timer_pkg::RELOAD_LOW_IDX, timer_pkg::RELOAD_HIGH_IDX,
            timer_pkg::STATUS_IDX, timer_pkg::MASK_IDX: begin
                mapped = (apb_in.paddr[1:0] == 2'h0);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Zero wait states: answer in the first access cycle
    assign pready_out = access;
    assign pslverr_out = access & ~mapped;
    assign prdata_out = prdata;
    // Level output, stays up until software clears the cause or its mask bit
    assign irq_out = |(status & mask);

    // Single-cycle events from the source edge
    always_comb begin
        events = 3'h0;
        events[timer_pkg::EV_TICK] = src_edge &
            (&count[timer_pkg::TICK_BITS-1:0]);
        events[timer_pkg::EV_WRAP] = src_edge & (&count);
        events[timer_pkg::EV_PIT] = src_edge & (pit_count == 12'h000);
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_count = count;
        next_low_hold = low_hold;
        next_snap_high = snap_high;
        next_pit_count = pit_count;
        next_pit_snap = pit_snap;
        next_reload = reload;
        next_mask = mask;
        next_prdata = prdata;
        // Counting; all ones rolls over to zero
        if (src_edge) begin
            next_count = count + 16'h0001;
            if (pit_count == 12'h000) begin
                next_pit_count = reload;
            end else begin
                next_pit_count = pit_count - 12'h001;
            end
        end
        // Writes land at the access edge; a write beats a count
        if (wr_acc) begin
            case (idx)
                timer_pkg::FREE_LOW_IDX: begin
                    next_low_hold = apb_in.pwdata[7:0];
                end
                timer_pkg::FREE_HIGH_IDX: begin
                    next_count = {apb_in.pwdata[7:0], low_hold};
                end
                timer_pkg::RELOAD_LOW_IDX: begin
                    next_reload[7:0] = apb_in.pwdata[7:0];
                end
                timer_pkg::RELOAD_HIGH_IDX: begin
                    next_reload[11:8] = apb_in.pwdata[3:0];
                end
                timer_pkg::MASK_IDX: begin
                    next_mask = apb_in.pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
        // Read data registered in setup; low reads take snapshots
        if (rd_setup) begin
            next_prdata = 32'h0000_0000;
            case (idx)
                timer_pkg::FREE_LOW_IDX: begin
                    next_prdata[7:0] = count[7:0];
                    next_snap_high = count[15:8];
                end
                timer_pkg::FREE_HIGH_IDX: begin
                    next_prdata[7:0] = snap_high;
                end
                timer_pkg::PIT_LOW_IDX: begin
                    next_prdata[7:0] = pit_count[7:0];
                    next_pit_snap = pit_count[11:8];
                end
                timer_pkg::PIT_HIGH_IDX: begin
                    next_prdata[3:0] = pit_snap;
                end
                timer_pkg::RELOAD_LOW_IDX: begin
                    next_prdata[7:0] = reload[7:0];
                end
                timer_pkg::RELOAD_HIGH_IDX: begin
                    next_prdata[3:0] = reload[11:8];
                end
                timer_pkg::STATUS_IDX: begin
                    next_prdata[2:0] = status;
                end
                timer_pkg::MASK_IDX: begin
                    next_prdata[2:0] = mask;
                end
                default: begin
                end
            endcase
        end
        // Write-one-to-clear; a new event wins over its clear
        next_status = status;
        if (wr_acc && idx == timer_pkg::STATUS_IDX) begin
            next_status = status & ~apb_in.pwdata[2:0];
        end
        next_status = next_status | events;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_meta <= 1'b0;
            src_sync <= 1'b0;
            src_prev <= 1'b0;
            count <= {2{timer_pkg::BYTE_RESET}};
            low_hold <= timer_pkg::BYTE_RESET;
            snap_high <= timer_pkg::BYTE_RESET;
            pit_count <= 12'h000;
            pit_snap <= 4'h0;
            reload <= 12'h000;
            status <= 3'h0;
            mask <= 3'h0;
            prdata <= 32'h0000_0000;
        end else begin
            src_meta <= timer_src_in;
            src_sync <= src_meta;
            src_prev <= src_sync;
            count <= next_count;
            low_hold <= next_low_hold;
            snap_high <= next_snap_high;
            pit_count <= next_pit_count;
            pit_snap <= next_pit_snap;
            reload <= next_reload;
            status <= next_status;
            mask <= next_mask;
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic wr_high;
    assign wr_high = wr_acc && idx == timer_pkg::FREE_HIGH_IDX;

    sequence s_low_read;
        rd_setup && idx == timer_pkg::FREE_LOW_IDX;
    endsequence

    sequence s_high_read;
        rd_setup && idx == timer_pkg::FREE_HIGH_IDX;
    endsequence

    a_count_advance: assert property (
        src_edge && !wr_high |=> count == 16'($past(count) + 16'h0001))
        else $error("counter did not advance on source edge");

    a_snap_pair: assert property (
        s_low_read |=> snap_high == $past(count[15:8]))
        else $error("high byte not captured at low byte read");

    // Low read, idle edge, then high read: the pair must form one snapshot
    a_snap_return: assert property (
        s_low_read ##3 s_high_read |=> prdata[7:0] == $past(count[15:8], 4))
        else $error("high byte read not the count taken at the low read");

    a_tick_moment: assert property (
        src_edge && (&count[11:0]) |=> status[timer_pkg::EV_TICK])
        else $error("tick event missing at low 12-bit rollover");

    a_wrap_event: assert property (
        src_edge && count == 16'hFFFF && !wr_high |=> status[timer_pkg::EV_WRAP] && count == 16'h0000)
        else $error("wrap not flagged or counter not zero");

    a_high_commit: assert property (
        wr_high |=> count == {$past(apb_in.pwdata[7:0]), $past(low_hold)})
        else $error("high byte write did not commit both bytes");

    a_pit_snap: assert property (
        rd_setup && idx == timer_pkg::PIT_LOW_IDX |=> pit_snap == $past(pit_count[11:8]))
        else $error("interval snapshot wrong");

    a_pit_high_res: assert property (
        rd_setup && idx == timer_pkg::PIT_HIGH_IDX |=> prdata[7:4] == 4'h0 && prdata[3:0] == pit_snap)
        else $error("interval high read wrong");

    a_pit_reload: assert property (
        src_edge && pit_count == 12'h000 |=> pit_count == $past(reload) && status[timer_pkg::EV_PIT])
        else $error("interval did not reload and flag");

    a_event_single: assert property (
        events[timer_pkg::EV_WRAP] |=> !events[timer_pkg::EV_WRAP])
        else $error("wrap event longer than one cycle");

    a_reload_high: assert property (
        wr_acc && idx == timer_pkg::RELOAD_HIGH_IDX
        |=> reload[11:8] == $past(apb_in.pwdata[3:0]) && reload[7:0] == $past(reload[7:0]))
        else $error("reload high nibble write wrong");

    a_reload_low: assert property (
        wr_acc && idx == timer_pkg::RELOAD_LOW_IDX
        |=> reload[7:0] == $past(apb_in.pwdata[7:0]) && reload[11:8] == $past(reload[11:8]))
        else $error("reload low byte write wrong");

    // A low byte write is only parked; the counter must not move with it
    a_low_hold: assert property (
        wr_acc && idx == timer_pkg::FREE_LOW_IDX && !src_edge
        |=> low_hold == $past(apb_in.pwdata[7:0]) && count == $past(count))
        else $error("low byte write reached the counter");

    a_count_hold: assert property (
        !src_edge && !wr_high |=> count == $past(count))
        else $error("counter moved without a source edge");

    a_tick_single: assert property (
        events[timer_pkg::EV_TICK] |=> !events[timer_pkg::EV_TICK])
        else $error("tick event longer than one cycle");

    a_pit_countdown: assert property (
        src_edge && pit_count != 12'h000 |=> pit_count == 12'($past(pit_count) - 12'h001))
        else $error("interval did not count down");

    a_pit_hold: assert property (
        !src_edge |=> pit_count == $past(pit_count))
        else $error("interval moved without a source edge");

    a_pit_single: assert property (
        events[timer_pkg::EV_PIT] |=> !events[timer_pkg::EV_PIT])
        else $error("interval event longer than one cycle");

    // A posted wrap event stays until software clears it
    a_status_sticky: assert property (
        status[timer_pkg::EV_WRAP]
        && !(wr_acc && idx == timer_pkg::STATUS_IDX && apb_in.pwdata[timer_pkg::EV_WRAP])
        |=> status[timer_pkg::EV_WRAP])
        else $error("wrap status lost without a clear");

    a_read_upper: assert property (
        rd_setup |=> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    // Edge only after the pin has crossed both synchroniser flops
    a_src_sync: assert property (
        src_edge |-> $past(timer_src_in, 2) && !$past(timer_src_in, 3))
        else $error("source edge not two flops behind the pin");

endmodule
`default_nettype wire

// ==== logic/timer_pkg.sv ====
// Constants, register map and bus carrier of the timer block
// Operation
// - 16-bit up counter on timer source
// - Low-byte read snapshots high byte
// - Periodic tick event every 1024 us
// - Wrap event on counter overflow
// - High-byte write commits both bytes
// - Counter bytes read-write, reset zero
// - Interval count read-only, low read snapshots
// - Count high nibble, bits 7:4 zero
// - Reload low byte, read-write, reset zero
// - Reload high nibble, bits 7:4 reserved
// - Timer source synchronised into register clock
package timer_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned SRC_HZ = 4_000_000;
    localparam int unsigned TICK_PERIOD_US = 1024;
    localparam int unsigned TICK_COUNTS = TICK_PERIOD_US * (SRC_HZ / 1_000_000);
    localparam int unsigned TICK_BITS = $clog2(TICK_COUNTS);

    // ****************************************
    // Register indices, byte address is four times these
    // ****************************************
    localparam logic [7:0] FREE_LOW_IDX = 8'h20;
    localparam logic [7:0] FREE_HIGH_IDX = 8'h21;
    localparam logic [7:0] PIT_LOW_IDX = 8'h26;
    localparam logic [7:0] PIT_HIGH_IDX = 8'h27;
    localparam logic [7:0] RELOAD_LOW_IDX = 8'h28;
    localparam logic [7:0] RELOAD_HIGH_IDX = 8'h29;
    localparam logic [7:0] STATUS_IDX = 8'h30;
    localparam logic [7:0] MASK_IDX = 8'h31;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned EV_TICK = 0;
    localparam int unsigned EV_WRAP = 1;
    localparam int unsigned EV_PIT = 2;
    localparam int unsigned EV_NUM = 3;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [9:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// ==== verif/test_free_interval_timer.sv ====
// Self-checking bench for the free-running and interval timer
`timescale 1ns/1ps
`default_nettype none
module test_free_interval_timer;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [7:0] FL = timer_pkg::FREE_LOW_IDX;
    localparam logic [7:0] FH = timer_pkg::FREE_HIGH_IDX;
    localparam logic [7:0] PL = timer_pkg::PIT_LOW_IDX;
    localparam logic [7:0] PH = timer_pkg::PIT_HIGH_IDX;
    localparam logic [7:0] RL = timer_pkg::RELOAD_LOW_IDX;
    localparam logic [7:0] RH = timer_pkg::RELOAD_HIGH_IDX;
    localparam logic [7:0] ST = timer_pkg::STATUS_IDX;
    localparam logic [7:0] MK = timer_pkg::MASK_IDX;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic src;
    timer_pkg::apb_req_t req = '0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic irq_out;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] regs [8] = '{FL, FH, PL, PH, RL, RH, ST, MK};

    free_interval_timer uut (.clk_in(clk_in), .rstn_in(rstn_in), .timer_src_in(src),
        .apb_in(req), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .irq_out(irq_out));
    timer_source_model model (.clk_in(clk_in), .src_out(src));

    // Free-running 100 MHz clock
    always #5 clk_in = ~clk_in;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen, the watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [31:0] rdata, output logic err);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= {24'h000000, d};
        @(posedge clk_in);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rdata = prdata_out;
        err = pslverr_out;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Idle edge: no strobe set twice in one step, outputs settle before checks
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, rd, er);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, rd, er);
        chk("read data", {24'h000000, exp}, rd);
        chk("error flag", 32'h00000000, {31'h00000000, er});
    endtask

    task automatic irqc(input logic exp);
        chk("interrupt", {31'h00000000, exp}, {31'h00000000, irq_out});
    endtask

    // Source burst, then time for synchroniser and status to settle
    task automatic edges(input int n);
        model.pulses(n);
        repeat (4) @(posedge clk_in);
    endtask

    task automatic complete_run();
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    // Whole run is well under a thousand cycles; ten thousand leave ample margin
    initial begin
        #100us;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            rdc(regs[i], 8'h00);
        end
        xfer(1'b0, 8'h22, 8'h00, rd, er);
        chk("unmapped error", 32'h00000001, {31'h00000000, er});
        chk("unmapped data", 32'h00000000, rd);
        // Reload low byte first, upper nibble after; reserved bits drop
        wr(RL, 8'h5A);
        wr(RH, 8'hF3);
        rdc(RL, 8'h5A);
        rdc(RH, 8'h03);
        // Low write alone must not reach the counter
        wr(FL, 8'h34);
        rdc(FL, 8'h00);
        wr(FH, 8'h12);
        rdc(FL, 8'h34);
        rdc(FH, 8'h12);
        // Snapshot of high byte survives a count across the byte boundary
        wr(FL, 8'hFF);
        wr(FH, 8'h00);
        rdc(FL, 8'hFF);
        edges(1);
        rdc(FH, 8'h00);
        rdc(FL, 8'h00);
        rdc(FH, 8'h01);
        rdc(ST, 8'h04);
        // Wrap boundary with all events masked
        wr(ST, 8'h07);
        wr(MK, 8'h00);
        wr(FL, 8'hFE);
        wr(FH, 8'hFF);
        edges(1);
        rdc(ST, 8'h00);
        edges(1);
        rdc(ST, 8'h03);
        irqc(1'b0);
        rdc(FL, 8'h00);
        rdc(FH, 8'h00);
        rdc(PL, 8'h58);
        rdc(PH, 8'h03);
        // Mask, then clear one bit at a time
        wr(MK, 8'h07);
        irqc(1'b1);
        wr(ST, 8'h01);
        rdc(ST, 8'h02);
        irqc(1'b1);
        wr(MK, 8'h01);
        irqc(1'b0);
        wr(ST, 8'h02);
        rdc(ST, 8'h00);
        // Tick alone at a 12-bit rollover; wrap must stay quiet
        wr(FL, 8'hFE);
        wr(FH, 8'h0F);
        edges(2);
        rdc(ST, 8'h01);
        irqc(1'b1);
        rdc(FL, 8'h00);
        rdc(FH, 8'h10);
        // Interval count is read-only: a write leaves it alone
        wr(PL, 8'hAA);
        rdc(PL, 8'h56);
        rdc(PH, 8'h03);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== verif/timer_source_model.sv ====
// Timer source model that gives rising edges on request
`timescale 1ns/1ps
`default_nettype none
module timer_source_model (
    input wire logic clk_in,
    output logic src_out
);
    // ****************************************
    // Edge generator
    // ****************************************
    // Source idles low between bursts so no stray count slips in
    initial begin
        src_out = 1'b0;
    end

    // Three cycles per level clears the two-cycle minimum of the synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            src_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            src_out <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
    endtask
endmodule
`default_nettype wire
